// ===== common/tad_pkg.sv
// package: address map constants and decode carrier types for the terminal address decoder
package tad_pkg;

    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    localparam int ROW_IDX_W = 8;
    localparam int ROW_DEPTH = 256;

    // -------------------------------------------------------------------------
    // address field positions
    // -------------------------------------------------------------------------
    localparam int EE_OFS_W = 11;
    localparam int RAM32_OFS_W = 15;
    localparam int RAM128_OFS_W = 17;
    localparam int ROW_IDX_LSB = 1;
    localparam int IO_PORT_LSB = 1;

    // -------------------------------------------------------------------------
    // decoded windows: base and mask of address bits that must match
    // -------------------------------------------------------------------------
    localparam logic [19:0] EE_SPACE_BASE = 20'h20000;
    localparam logic [19:0] EE_SPACE_MASK = 20'he0000;
    // bit 14 and 13 of the address inside the eeprom space
    localparam int EE_RW_BIT = 14;
    localparam int EE_USED_BIT = 13;
    localparam logic [19:0] RAM_BASE = 20'h80000;
    localparam logic [19:0] RAM_MASK = 20'hc0000;
    localparam logic [19:0] ROW_BASE = 20'ha0000;
    localparam logic [19:0] ROW_MASK = 20'he0000;
    localparam logic [19:0] SERIAL_BASE = 20'h40000;
    localparam logic [19:0] KEYB_BASE = 20'h44000;
    localparam logic [19:0] SYSCTL_BASE = 20'h48000;
    localparam logic [19:0] IO_MASK = 20'hfc000;

    // -------------------------------------------------------------------------
    // port offsets inside the i/o windows
    // -------------------------------------------------------------------------
    localparam logic [2:0] SER_AUX_CMD_OFS = 3'h0;
    localparam logic [2:0] SER_MAIN_CMD_OFS = 3'h2;
    localparam logic [2:0] SER_AUX_DATA_OFS = 3'h4;
    localparam logic [2:0] SER_MAIN_DATA_OFS = 3'h6;
    localparam logic [1:0] KEYB_DATA_OFS = 2'h0;
    localparam logic [1:0] KEYB_CMD_OFS = 2'h2;

    typedef enum logic [1:0] {
        TAD_SER_AUX_CMD,
        TAD_SER_MAIN_CMD,
        TAD_SER_AUX_DATA,
        TAD_SER_MAIN_DATA
    } tad_ser_port_t;

    typedef struct packed {
        logic eeprom;
        logic eeprom_rd_ok;
        logic ram;
        logic serial_comm_select;
        logic keyb;
        logic system_control_select;
    } tad_sel_t;

    typedef struct packed {
        logic [19:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } tad_bus_t;

endpackage

// ===== core/tad_decoder.sv
// terminal address decoder: bus cycle to device selects, eeprom/ram aliasing, row-table shadow
`timescale 1ns/1ns
module tad_decoder
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ram_128k_i,
    input wire logic [19:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [7:0] row_rd_idx_i,
    output logic eeprom_sel_o,
    output logic eeprom_we_o,
    output logic [10:0] eeprom_addr_o,
    output logic ram_sel_o,
    output logic ram_we_o,
    output logic [16:0] ram_addr_o,
    output logic serial_comm_select_o,
    output logic [1:0] serial_port_o,
    output logic keyb_sel_o,
    output logic keyb_cmd_o,
    output logic system_control_select_o,
    output logic [7:0] row_rd_data_o
);

    // -------------------------------------------------------------------------
    // address window decode
    // -------------------------------------------------------------------------
    // pure combinational decode: selects follow the bus cycle, no state needed
    tad_pkg::tad_sel_t sel;
    logic active;
    logic in_ee_space;
    logic in_ram;
    logic in_row;
    logic ee_used;
    logic ee_rw_blk;

    assign active = rd_i | wr_i;
    assign in_ee_space = (addr_i & tad_pkg::EE_SPACE_MASK) == tad_pkg::EE_SPACE_BASE;
    assign ee_used = addr_i[tad_pkg::EE_USED_BIT];
    assign ee_rw_blk = addr_i[tad_pkg::EE_RW_BIT];
    assign in_ram = (addr_i & tad_pkg::RAM_MASK) == tad_pkg::RAM_BASE;
    assign in_row = (addr_i & tad_pkg::ROW_MASK) == tad_pkg::ROW_BASE;

    always_comb
    begin
        sel = '0;
        if (active)
        begin
            // even 8K blocks are decoded but dead
            sel.eeprom = in_ee_space & ee_used;
            sel.eeprom_rd_ok = in_ee_space & ee_used & ee_rw_blk;
            sel.ram = in_ram;
            sel.serial_comm_select = (addr_i & tad_pkg::IO_MASK) == tad_pkg::SERIAL_BASE;
            sel.keyb = (addr_i & tad_pkg::IO_MASK) == tad_pkg::KEYB_BASE;
            sel.system_control_select = (addr_i & tad_pkg::IO_MASK) == tad_pkg::SYSCTL_BASE;
        end
    end

    // -------------------------------------------------------------------------
    // select outputs
    // -------------------------------------------------------------------------
    // read in a write-only eeprom block drops the select: the part must not drive the bus
    assign eeprom_sel_o = sel.eeprom & (wr_i | sel.eeprom_rd_ok);
    assign eeprom_we_o = sel.eeprom & wr_i;
    assign eeprom_addr_o = addr_i[tad_pkg::EE_OFS_W-1:0];
    assign ram_sel_o = sel.ram;
    assign ram_we_o = sel.ram & wr_i;
    // 32K build ignores bits 17:15 so all eight aliases land on one bank
    assign ram_addr_o = ram_128k_i ? addr_i[tad_pkg::RAM128_OFS_W-1:0]
                                   : {2'h0, addr_i[tad_pkg::RAM32_OFS_W-1:0]};
    assign serial_comm_select_o = sel.serial_comm_select;
    assign keyb_sel_o = sel.keyb;
    assign system_control_select_o = sel.system_control_select;

    // -------------------------------------------------------------------------
    // port select inside i/o windows
    // -------------------------------------------------------------------------
    always_comb
    begin
        case (addr_i[2:0])
            tad_pkg::SER_AUX_CMD_OFS: serial_port_o = 2'(tad_pkg::TAD_SER_AUX_CMD);
            tad_pkg::SER_MAIN_CMD_OFS: serial_port_o = 2'(tad_pkg::TAD_SER_MAIN_CMD);
            tad_pkg::SER_AUX_DATA_OFS: serial_port_o = 2'(tad_pkg::TAD_SER_AUX_DATA);
            tad_pkg::SER_MAIN_DATA_OFS: serial_port_o = 2'(tad_pkg::TAD_SER_MAIN_DATA);
            // odd bytes reuse the even port, as the partial decode does
            default: serial_port_o = addr_i[2:1];
        endcase
    end

    assign keyb_cmd_o = addr_i[1:0] == tad_pkg::KEYB_CMD_OFS;

    // -------------------------------------------------------------------------
    // row-table static ram shadow
    // -------------------------------------------------------------------------
    logic [7:0] row_mem [tad_pkg::ROW_DEPTH];
    logic row_we;
    logic [7:0] row_widx;
    logic [7:0] row_rd_data_r;

    assign row_we = wr_i & in_row & ~addr_i[0];
    assign row_widx = addr_i[tad_pkg::ROW_IDX_LSB +: tad_pkg::ROW_IDX_W];

    always_ff @(posedge clk_i)
    begin
        if (row_we)
        begin
            row_mem[row_widx] <= wdata_i;
        end
    end

    // only the display side reads the table; the processor bus has no path here
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            row_rd_data_r <= 8'h00;
        end
        else
        begin
            row_rd_data_r <= row_mem[row_rd_idx_i];
        end
    end

    assign row_rd_data_o = row_rd_data_r;

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    logic [7:0] last_widx;
    logic [7:0] last_wdata;
    logic last_valid;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            last_widx <= 8'h00;
            last_wdata <= 8'h00;
            last_valid <= 1'b0;
        end
        else if (row_we)
        begin
            last_widx <= row_widx;
            last_wdata <= wdata_i;
            last_valid <= 1'b1;
        end
    end

    chk_ee_wronly_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rd_i && !wr_i && in_ee_space && !addr_i[tad_pkg::EE_RW_BIT]) |-> !eeprom_sel_o)
        else $error("eeprom selected on read of write-only block");

    chk_ee_dead_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (in_ee_space && !addr_i[tad_pkg::EE_USED_BIT]) |-> !(eeprom_sel_o || eeprom_we_o))
        else $error("eeprom selected in unused block");

    chk_ram_alias32: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!ram_128k_i && ram_sel_o) |-> (ram_addr_o == {2'h0, addr_i[14:0]}))
        else $error("32K ram alias address wrong");

    chk_ram_alias128: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ram_128k_i && active && addr_i[19:18] == 2'h2) |-> (ram_sel_o && ram_addr_o == addr_i[16:0]))
        else $error("128K ram alias not selected");

    chk_row_shadow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (row_we && row_rd_idx_i == row_widx) ##1 (row_rd_idx_i == last_widx && !row_we && last_valid)
        |=> (row_rd_data_o == last_wdata))
        else $error("row table did not hold written byte");

    chk_row_dram_too: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        row_we |-> (ram_we_o && ram_sel_o))
        else $error("row table write missed dynamic ram");

    chk_row_even_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_i && in_row && addr_i[0]) |-> !row_we)
        else $error("odd address wrote row table");

    chk_serial_window: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        serial_comm_select_o |-> (active && addr_i[19:14] == 6'h10))
        else $error("serial select outside its window");

    chk_keyb_window: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        keyb_sel_o |-> (active && addr_i[19:14] == 6'h11))
        else $error("keyboard select outside its window");

    chk_sysctl_window: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        system_control_select_o |-> (active && addr_i[19:14] == 6'h12))
        else $error("system control select outside its window");

    chk_serial_ports: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (serial_comm_select_o && addr_i[2:0] == 3'h6) |-> (serial_port_o == 2'h3))
        else $error("main data port misdecoded");

    chk_keyb_ports: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (keyb_sel_o && addr_i == 20'h44000) |-> !keyb_cmd_o)
        else $error("keyboard data port misdecoded");

    chk_keyb_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (keyb_sel_o && addr_i == 20'h44002) |-> keyb_cmd_o)
        else $error("keyboard command port misdecoded");

    chk_row_no_cpu_rd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rd_i && in_row) |-> !row_we)
        else $error("processor read touched row table");

    chk_one_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $onehot0({eeprom_sel_o, ram_sel_o, serial_comm_select_o, keyb_sel_o, system_control_select_o}))
        else $error("more than one select active");

    chk_idle_no_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !active |-> !(eeprom_sel_o || ram_sel_o || serial_comm_select_o || keyb_sel_o || system_control_select_o))
        else $error("select active with no bus cycle");

    // -------------------------------------------------------------------------
    // checks: decode completeness, the selects that must come and the ones that must stay off
    // -------------------------------------------------------------------------
    chk_ee_rw_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rd_i && !wr_i && in_ee_space && ee_used && ee_rw_blk) |-> (eeprom_sel_o && !eeprom_we_o))
        else $error("eeprom not selected on read of read/write block");

    chk_ee_write_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_i && in_ee_space && ee_used) |-> (eeprom_sel_o && eeprom_we_o))
        else $error("eeprom not written in used block");

    chk_ee_alias_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        eeprom_sel_o |-> (eeprom_addr_o == addr_i[10:0]))
        else $error("eeprom alias address wrong");

    chk_ee_dead_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (active && in_ee_space && !ee_used)
        |-> !(eeprom_sel_o || ram_sel_o || serial_comm_select_o || keyb_sel_o || system_control_select_o || row_we))
        else $error("unused eeprom block selected something");

    chk_ram_alias_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!ram_128k_i && active && addr_i[19:18] == 2'h2) |-> ram_sel_o)
        else $error("32K ram alias not selected");

    chk_ram_we_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_i && ram_sel_o) |-> ram_we_o)
        else $error("ram write not strobed");

    chk_ram_rd_no_we: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rd_i && !wr_i && ram_sel_o) |-> !ram_we_o)
        else $error("ram written on a read");

    chk_row_mem_store: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        row_we |=> (row_mem[last_widx] == last_wdata))
        else $error("row table entry not stored");

    chk_row_dram_pair: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        row_we |-> (ram_addr_o[8:1] == row_widx))
        else $error("row entry and dram location do not pair");

    chk_serial_in: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (active && addr_i[19:14] == 6'h10) |-> serial_comm_select_o)
        else $error("serial window not selected");

    chk_keyb_in: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (active && addr_i[19:14] == 6'h11) |-> keyb_sel_o)
        else $error("keyboard window not selected");

    chk_sysctl_in: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (active && addr_i[19:14] == 6'h12) |-> system_control_select_o)
        else $error("system control window not selected");

    chk_ser_aux_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (serial_comm_select_o && addr_i[2:0] == 3'h0) |-> (serial_port_o == 2'h0))
        else $error("aux command port misdecoded");

    chk_ser_main_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (serial_comm_select_o && addr_i[2:0] == 3'h2) |-> (serial_port_o == 2'h1))
        else $error("main command port misdecoded");

    chk_ser_aux_data: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (serial_comm_select_o && addr_i[2:0] == 3'h4) |-> (serial_port_o == 2'h2))
        else $error("aux data port misdecoded");

    chk_keyb_data_even: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (keyb_sel_o && addr_i[1:0] == 2'h0) |-> !keyb_cmd_o)
        else $error("keyboard data alias misdecoded");

    chk_unmapped_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (addr_i[19:18] == 2'h3 || addr_i[19:17] == 3'h0 || (addr_i[19:18] == 2'h1 && addr_i[17:14] > 4'h2))
        |-> !(eeprom_sel_o || ram_sel_o || serial_comm_select_o || keyb_sel_o || system_control_select_o))
        else $error("select active in unmapped range");

    chk_ram_outside: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ram_sel_o |-> (active && addr_i[19:18] == 2'h2))
        else $error("ram selected outside its window");

endmodule // tad_decoder

// ===== verification/tad_cpu_model.sv
// processor bus model that runs byte cycles against the decoder
`timescale 1ns/1ns
module tad_cpu_model
(
    input wire logic clk_i,
    output tad_pkg::tad_bus_t bus_o
);
    initial
    begin
        bus_o = '0;
    end

    // one cycle per clock, launched off the falling edge; read wins over write
    task automatic cycle(input logic [19:0] a, input logic [7:0] d, input logic r, input logic w);
        @(negedge clk_i);
        bus_o.addr = a;
        bus_o.wdata = d;
        bus_o.rd = r;
        bus_o.wr = w & ~r;
        @(posedge clk_i);
    endtask

    // released lines do not keep the last value
    task automatic idle();
        @(negedge clk_i);
        bus_o.addr = ~bus_o.addr;
        bus_o.wdata = ~bus_o.wdata;
        bus_o.rd = 1'b0;
        bus_o.wr = 1'b0;
    endtask
endmodule // tad_cpu_model

// ===== verification/terminal_address_decoder_tb.sv
// self-checking bench for the terminal address decoder
`timescale 1ns/1ns
module terminal_address_decoder_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ram_128k_i = 1'b0;
    logic [7:0] row_rd_idx_i = 8'h00;
    tad_pkg::tad_bus_t bus;
    logic ee_s, ee_w, ram_s, ram_w, ser_s, kb_s, kb_c, sys_s;
    logic [1:0] port;
    logic [10:0] ee_a;
    logic [16:0] ram_a;
    logic [7:0] row_d;
    logic [37:0] obs, e_m, mask;
    logic [37:0] exp_q[$];
    logic [7:0] row_m[256];
    bit row_ok[256];
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    localparam logic [19:0] DIR[26] = '{20'h21fff, 20'h22000, 20'h227ff, 20'h26000, 20'h2a000, 20'h2e7ff,
        20'h30000, 20'h3fffe, 20'h40000, 20'h40002, 20'h40004, 20'h40006, 20'h43fff, 20'h44000, 20'h44002,
        20'h47fff, 20'h48000, 20'h4bfff, 20'h4c000, 20'h7ffff, 20'h80000, 20'ha0004, 20'ha0005, 20'hbfe08,
        20'hc0000, 20'ha0200};

    initial
    begin
        forever #20 clk_i = ~clk_i;
    end

    tad_cpu_model u_tad_cpu_model (.clk_i(clk_i), .bus_o(bus));
    tad_decoder u_tad_decoder (.clk_i(clk_i), .rst_n_i(rst_n_i), .ram_128k_i(ram_128k_i), .addr_i(bus.addr),
        .wdata_i(bus.wdata), .rd_i(bus.rd), .wr_i(bus.wr), .row_rd_idx_i(row_rd_idx_i), .eeprom_sel_o(ee_s),
        .eeprom_we_o(ee_w), .eeprom_addr_o(ee_a), .ram_sel_o(ram_s), .ram_we_o(ram_w), .ram_addr_o(ram_a),
        .serial_comm_select_o(ser_s), .serial_port_o(port), .keyb_sel_o(kb_s), .keyb_cmd_o(kb_c),
        .system_control_select_o(sys_s), .row_rd_data_o(row_d));

    assign obs = {ee_s, ee_w, ram_s, ram_w, ser_s, kb_s, sys_s, port, kb_c, ram_a, ee_a};

    // --------------------------------------------------------------
    // reference decode and compare tasks
    // --------------------------------------------------------------
    function automatic logic [37:0] exp_vec(input logic [19:0] a, input logic w, input logic big);
        logic ee;
        logic rm;
        ee = (a[19:17] == 3'h1) && a[13] && (w || a[14]);
        rm = (a[19:18] == 2'h2);
        return {ee, ee & w, rm, rm & w, a[19:14] == 6'h10, a[19:14] == 6'h11, a[19:14] == 6'h12, a[2:1],
            a[1:0] == 2'h2, big ? a[16:0] : {2'h0, a[14:0]}, a[10:0]};
    endfunction

    task automatic chk(input logic [37:0] got, input logic [37:0] want, input logic [37:0] m);
        checked++;
        if ((got & m) !== (want & m))
        begin
            failures++;
            $display("MISMATCH t=%0t decode got %h want %h", $time, got & m, want & m);
        end
    endtask

    task automatic op(input logic [19:0] a, input logic [7:0] d, input logic r);
        exp_q.push_back(exp_vec(a, ~r, ram_128k_i));
        u_tad_cpu_model.cycle(a, d, r, ~r);
    endtask

    task automatic row_chk(input logic [7:0] i, input logic [7:0] want);
        @(negedge clk_i);
        row_rd_idx_i = i;
        @(negedge clk_i);
        chk({30'h0, row_d}, {30'h0, want}, {30'h0, 8'hff});
    endtask

    task automatic stop_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // selects are combinational; sample them at the edge that ends the cycle
    always @(posedge clk_i)
    begin
        cycles++;
        if (bus.rd | bus.wr)
        begin
            e_m = exp_q.pop_front();
            mask = {7'h7f, {2{e_m[33]}}, e_m[32] & ~e_m[0], {17{e_m[35]}}, {11{e_m[37]}}};
            chk(obs, e_m, mask);
            if (bus.wr && bus.addr[19:17] == 3'h5 && !bus.addr[0])
            begin
                row_m[bus.addr[8:1]] = bus.wdata;
                row_ok[bus.addr[8:1]] = 1'b1;
            end
        end
        if (cycles == 20000)
        begin
            failures++;
            stop_test();
        end
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        logic [19:0] ra;
        void'($urandom(32'hdbc1));
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        rst_n_i = 1'b1;
        for (int b = 0; b < 2; b++)
        begin
            ram_128k_i = b[0];
            foreach (DIR[k])
            begin
                op(DIR[k], 8'(k * 37 + b), 1'b0);
                op(DIR[k], 8'h00, 1'b1);
            end
            repeat (300)
            begin
                ra = 20'($urandom());
                ra[19:16] = 4'($urandom_range(11, 0));
                op(ra, 8'($urandom()), 1'($urandom()));
            end
            u_tad_cpu_model.idle();
        end
        for (int i = 0; i < 256; i++)
            if (row_ok[i])
                row_chk(8'(i), row_m[i]);
        @(negedge clk_i);
        rst_n_i = 1'b0;
        @(negedge clk_i);
        chk({30'h0, row_d}, 38'h0, {30'h0, 8'hff});
        rst_n_i = 1'b1;
        // table contents survive a reset
        row_chk(8'h02, row_m[2]);
        stop_test();
    end
endmodule // terminal_address_decoder_tb
